/* File: design/status_diag.sv */
// system status and diagnosis read-back with mode register write
//
// Functional notes
// - status bit 1 follows the enable pin drive level.
// - power-on flag set by power-on reset, cleared on Normal mode entry.
// - reset source overwritten each reset event; reading does not clear it.
// - diagnosis word readable in every mode.
// - select bits 00 with read select 1 return the diagnosis word.
// - read-only 1 returns the word and keeps the mode register.
// - read-only 0 returns the word and loads the mode register.
// - bit 11 shows ground shift outside threshold.
// - CAN fault code bits 10..7 carry the clamp fault codes.
// - CAN fault code carries wiring fault codes; 0000 no failure.
// - LIN fault code 11, 10, 01 faults, 00 none.
// - aux supply bit 1 healthy, 0 when switched off by overload.
// - transceiver supply bit 3 1 healthy, 0 when off by overload.
// - transceiver supply bit returns to 1 when supply is back on.
// - core supply bit latches 0 on undervoltage; a diagnosis read sets it unless undervoltage is present in the same cycle.
// - CAN mode report 11 active, 10 on-line, 01 listen, 00 off.
// - select bits 00 with read select 0 return the status word.
// - supply fault enable makes a supply bit clearing raise an interrupt.
// - CAN fault enable makes a CAN fault code change raise an interrupt.
`timescale 1ns/100ps
`default_nettype none
module status_diag
  import diag_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  // frame from the serial interface
  input  wire logic                       frame_valid,
  input  wire logic [diag_pkg::FRAME_W-1:0] frame_in,
  // reset event report
  input  wire logic                       reset_event,
  input  wire logic [3:0]                 reset_cause,
  input  wire logic                       power_on_reset,
  input  wire logic                       normal_entered,
  // status inputs
  input  wire logic                       enable_pin_high,
  input  wire logic [6:0]                 status_misc,
  // diagnosis inputs
  input  wire logic                       ground_shift_out,
  input  wire logic [3:0]                 can_fault_code,
  input  wire logic [1:0]                 lin_fault_code,
  input  wire logic                       aux_supply_ok,
  input  wire logic                       transceiver_supply_ok,
  input  wire logic                       core_supply_uv,
  input  wire logic [1:0]                 can_mode,
  // interrupt enables
  input  wire logic                       supply_fault_irq_enable,
  input  wire logic                       can_fault_irq_enable,
  // answers
  output logic                            read_valid,
  output logic [diag_pkg::FRAME_W-1:0]    read_data,
  output logic [diag_pkg::MODE_W-1:0]    mode_reg,
  output logic                            mode_write,
  output logic                            supply_irq,
  output logic                            can_fault_irq
);
  import diag_pkg::*;

  logic [3:0]        rss_q;
  logic              pwon_q;
  logic              ens_q;
  logic [15:0]       rd_q;
  logic              rdv_q;
  logic [MODE_W-1:0] mode_q;
  logic              mw_q;
  logic              sirq_q;
  logic              cirq_q;
  logic              v1_ok_q;
  logic              v2_ok_q;
  logic              v3_ok_q;
  rd_state_t         st_d;

  // frame decode
  wire logic        sys_sel  = frame_in[ADDR_HI:ADDR_LO] == SYS_ADDR;
  wire logic        hit      = frame_valid && sys_sel;
  wire logic        want_dg  = frame_in[RSEL_BIT];
  wire logic        ro       = frame_in[RO_BIT];
  wire logic        diag_rd  = hit && want_dg;

  // transceiver supply health, sampled as a level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v2_ok_q <= 1'b1;
    end else begin
      v2_ok_q <= transceiver_supply_ok;
    end
  end

  // aux supply health, sampled as a level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      v3_ok_q <= 1'b1;
    end else begin
      v3_ok_q <= aux_supply_ok;
    end
  end

  // enable pin drive level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ens_q <= 1'b0;
    end else begin
      ens_q <= enable_pin_high;
    end
  end

  sticky_low u_v1 (
    .clk_sys (clk_sys),
    .srst    (srst),
    .fault   (core_supply_uv),
    .restore (diag_rd),
    .ok_q    (v1_ok_q)
  );

  // status word fields
  wire logic [3:0]  echo_bits  = frame_in[ADDR_HI:RO_BIT];
  wire logic [3:0]  rss_field  = rss_q;
  wire logic [5:0]  misc_field = status_misc[6:1];
  wire logic        ens_field  = ens_q;
  wire logic        pwon_field = pwon_q;

  // diagnosis word fields, readable in every mode
  wire logic        gsd_field  = ground_shift_out;
  wire logic [3:0]  canf_field = can_fault_code;
  wire logic [1:0]  linf_field = lin_fault_code;
  wire logic        v3_field   = v3_ok_q;
  wire logic        v2_field   = v2_ok_q;
  wire logic        v1_field   = v1_ok_q;
  // an inactive transceiver supply reports the off-line code
  wire logic [1:0]  canm_field = v2_ok_q ? can_mode
                                         : CANM_OFFLINE;

  // word assembly
  wire logic [15:0] stat_word = {echo_bits, rss_field, misc_field,
                                 ens_field, pwon_field};
  wire logic [15:0] diag_word = {echo_bits, gsd_field, canf_field,
                                 linf_field, v3_field, v2_field,
                                 v1_field, canm_field};

  always_comb begin
    st_d = RD_IDLE;
    if (hit) begin
      st_d = want_dg ? RD_DIAG : RD_STAT;
    end
  end

  // reset source, overwritten by every reset event
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rss_q <= RSS_POR;
    end else if (reset_event) begin
      rss_q <= reset_cause;
    end
  end

  // power-on flag; a power-on reset wins over Normal entry
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pwon_q <= 1'b1;
    end else if (power_on_reset) begin
      pwon_q <= 1'b1;
    end else if (normal_entered) begin
      pwon_q <= 1'b0;
    end
  end

  // answer strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= hit;
    end
  end

  // answer word, held until the next accepted frame
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_q <= WORD_RST;
    end else begin
      unique case (st_d)
        RD_STAT: rd_q <= stat_word;
        RD_DIAG: rd_q <= diag_word;
        RD_IDLE: rd_q <= rd_q;
        default: rd_q <= rd_q;
      endcase
    end
  end

  // mode register write, only when the read-only flag is clear
  wire logic        mode_ld = hit && !ro;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mw_q <= 1'b0;
    end else begin
      mw_q <= mode_ld;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q <= MODE_RST;
    end else if (mode_ld) begin
      mode_q <= frame_in[MODE_W-1:0];
    end
  end

  // interrupt events
  logic v_fell;
  logic c_chg;

  change_detect #(.W(3)) u_vchg (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .value     ({v3_ok_q, v2_ok_q, v1_ok_q}),
    .rst_value (3'h7),
    .changed   (),
    .fell      (v_fell)
  );

  change_detect #(.W(4)) u_cchg (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .value     (can_fault_code),
    .rst_value (CANF_NONE),
    .changed   (c_chg),
    .fell      ()
  );

  // supply fault interrupt on any supply bit clearing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sirq_q <= 1'b0;
    end else begin
      sirq_q <= supply_fault_irq_enable && v_fell;
    end
  end

  // CAN fault interrupt on any code change
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cirq_q <= 1'b0;
    end else begin
      cirq_q <= can_fault_irq_enable && c_chg;
    end
  end

  assign read_valid = rdv_q;
  assign read_data = rd_q;
  assign mode_reg = mode_q;
  assign mode_write = mw_q;
  assign supply_irq = sirq_q;
  assign can_fault_irq = cirq_q;
endmodule
`default_nettype wire

/* File: design/diag_pkg.sv */
// constants for the status and diagnosis read-back block
package diag_pkg;
  localparam int FRAME_W = 16;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam int RSEL_BIT = 13;
  localparam int RO_BIT = 12;
  localparam logic [1:0] SYS_ADDR = 2'h0;
  localparam int MODE_W = 12;
  // status word fields
  localparam int RSS_HI = 11;
  localparam int RSS_LO = 8;
  localparam int ENS_BIT = 1;
  localparam int PWON_BIT = 0;
  // diagnosis word fields
  localparam int GSD_BIT = 11;
  localparam int CANF_HI = 10;
  localparam int CANF_LO = 7;
  localparam int LINF_HI = 6;
  localparam int LINF_LO = 5;
  localparam int V3D_BIT = 4;
  localparam int V2D_BIT = 3;
  localparam int V1D_BIT = 2;
  localparam int CANM_HI = 1;
  localparam int CANM_LO = 0;
  localparam logic [3:0] RSS_POR = 4'h0;
  localparam logic [3:0] CANF_NONE = 4'h0;
  localparam logic [1:0] LINF_NONE = 2'h0;
  localparam logic [1:0] CANM_OFFLINE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_STAT = 2'b01,
    RD_DIAG = 2'b10
  } rd_state_t;
endpackage

/* File: design/change_detect.sv */
// flags any change or any falling edge of a sampled field
`timescale 1ns/100ps
`default_nettype none
module change_detect #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         srst,
  // field
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] rst_value,
  // events
  output logic              changed,
  output logic              fell
);
  logic [W-1:0] prev_q;

  // starts from the field's reset level, so no false event follows reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev_q <= rst_value;
    end else begin
      prev_q <= value;
    end
  end

  assign changed = !srst && (prev_q != value);
  assign fell = !srst && |(prev_q & ~value);
endmodule
`default_nettype wire

/* File: design/sticky_low.sv */
// latch that drops on a fault and is restored by a read
`timescale 1ns/100ps
`default_nettype none
module sticky_low (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // events
  input  wire logic fault,
  input  wire logic restore,
  // state
  output logic      ok_q
);
  // a fault in the same cycle as a restore wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ok_q <= 1'b1;
    end else if (fault) begin
      ok_q <= 1'b0;
    end else if (restore) begin
      ok_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/status_diag_sva.sv */
// assertions on the read-back block ports
`timescale 1ns/100ps
`default_nettype none
module status_diag_sva
  import diag_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // inputs
  input wire logic        frame_valid,
  input wire logic [15:0] frame_in,
  input wire logic        enable_pin_high,
  input wire logic [3:0]  can_fault_code,
  input wire logic        transceiver_supply_ok,
  input wire logic        supply_fault_irq_enable,
  input wire logic        can_fault_irq_enable,
  // outputs
  input wire logic        read_valid,
  input wire logic [15:0] read_data,
  input wire logic [11:0] mode_reg,
  input wire logic        mode_write,
  input wire logic        supply_irq,
  input wire logic        can_fault_irq
);
  wire acc = frame_valid && frame_in[ADDR_HI:ADDR_LO] == SYS_ADDR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_stat; acc && !frame_in[RSEL_BIT]; endsequence
  sequence s_diag; acc && frame_in[RSEL_BIT]; endsequence
  property p_answer; read_valid == $past(acc); endproperty
  a_answer: assert property (p_answer) else $error("bad answer");
  property p_keep; acc && frame_in[RO_BIT] |=>
    !mode_write && $stable(mode_reg); endproperty
  a_keep: assert property (p_keep) else $error("mode changed");
  property p_load; acc && !frame_in[RO_BIT] |=>
    mode_write && mode_reg == $past(frame_in[11:0]); endproperty
  a_load: assert property (p_load) else $error("mode not loaded");
  property p_ens; s_stat ##0 $stable(enable_pin_high) |=>
    read_data[ENS_BIT] == $past(enable_pin_high); endproperty
  a_ens: assert property (p_ens) else $error("enable bit");
  property p_canf; s_diag ##0 $stable(can_fault_code) |=>
    read_data[CANF_HI:CANF_LO] == $past(can_fault_code); endproperty
  a_canf: assert property (p_canf) else $error("can code");
  property p_xcvr; s_diag ##0 $stable(transceiver_supply_ok) |=>
    read_data[V2D_BIT] == $past(transceiver_supply_ok); endproperty
  a_xcvr: assert property (p_xcvr) else $error("xcvr bit");
  property p_cirq; can_fault_irq_enable && $changed(can_fault_code) |->
    ##[1:3] can_fault_irq; endproperty
  a_cirq: assert property (p_cirq) else $error("no can irq");
  property p_sirq; supply_fault_irq_enable && $fell(transceiver_supply_ok)
    |-> ##[1:4] supply_irq; endproperty
  a_sirq: assert property (p_sirq) else $error("no supply irq");
  property p_offline; s_diag ##0 !transceiver_supply_ok ##0
    $stable(transceiver_supply_ok) |=>
    read_data[CANM_HI:CANM_LO] == CANM_OFFLINE; endproperty
  a_offline: assert property (p_offline) else $error("can mode");
endmodule
bind status_diag status_diag_sva i_sva (
  .clk_sys(clk_sys), .srst(srst), .frame_valid(frame_valid),
  .frame_in(frame_in), .enable_pin_high(enable_pin_high),
  .can_fault_code(can_fault_code),
  .transceiver_supply_ok(transceiver_supply_ok),
  .supply_fault_irq_enable(supply_fault_irq_enable),
  .can_fault_irq_enable(can_fault_irq_enable), .read_valid(read_valid),
  .read_data(read_data), .mode_reg(mode_reg), .mode_write(mode_write),
  .supply_irq(supply_irq), .can_fault_irq(can_fault_irq)
);
`default_nettype wire

/* File: tb/host_model.sv */
// host model sending register frames and taking answers
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // clock
  input  wire logic        clk_sys,
  // answer
  input  wire logic        read_valid,
  input  wire logic [15:0] read_data,
  // request
  output logic             frame_valid,
  output logic [15:0]      frame_in
);
  initial begin
    frame_valid = 1'b0;
    frame_in    = 16'h0000;
  end
  // one frame; the answer is read at the next falling edge, half a cycle after the frame is taken
  task automatic xfer(input logic [15:0] f, output logic [15:0] d,
                      output logic ok);
    @(negedge clk_sys);
    frame_valid = 1'b1;
    frame_in    = f;
    @(negedge clk_sys);
    frame_valid = 1'b0;
    frame_in    = ~f;
    ok          = read_valid;
    d           = read_data;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_system_status_diagnosis_readback.sv */
// testbench for the status and diagnosis read-back block
`timescale 1ns/100ps
`default_nettype none
module test_system_status_diagnosis_readback;
  logic clk_sys, srst, frame_valid, reset_event, power_on_reset, ok;
  logic normal_entered, enable_pin_high, ground_shift_out, aux_supply_ok;
  logic transceiver_supply_ok, core_supply_uv, read_valid, mode_write;
  logic supply_fault_irq_enable, can_fault_irq_enable;
  logic supply_irq, can_fault_irq;
  logic [15:0] frame_in, read_data, d;
  logic [11:0] mode_reg;
  logic [6:0]  status_misc;
  logic [3:0]  reset_cause, can_fault_code;
  logic [1:0]  lin_fault_code, can_mode;
  int          n_mismatch, n_checks;
  status_diag i_dut (.clk_sys(clk_sys), .srst(srst),
    .frame_valid(frame_valid), .frame_in(frame_in),
    .reset_event(reset_event), .reset_cause(reset_cause),
    .power_on_reset(power_on_reset), .normal_entered(normal_entered),
    .enable_pin_high(enable_pin_high), .status_misc(status_misc),
    .ground_shift_out(ground_shift_out), .can_fault_code(can_fault_code),
    .lin_fault_code(lin_fault_code), .aux_supply_ok(aux_supply_ok),
    .transceiver_supply_ok(transceiver_supply_ok),
    .core_supply_uv(core_supply_uv), .can_mode(can_mode),
    .supply_fault_irq_enable(supply_fault_irq_enable),
    .can_fault_irq_enable(can_fault_irq_enable), .read_valid(read_valid),
    .read_data(read_data), .mode_reg(mode_reg), .mode_write(mode_write),
    .supply_irq(supply_irq), .can_fault_irq(can_fault_irq));
  host_model i_host (.clk_sys(clk_sys), .read_valid(read_valid),
    .read_data(read_data), .frame_valid(frame_valid), .frame_in(frame_in));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] sw(input logic [3:0] rs, input logic pw);
    return {4'h1, rs, status_misc[6:1], enable_pin_high, pw};
  endfunction
  function automatic logic [15:0] dw(input logic [3:0] hi, input logic c);
    return {hi, ground_shift_out, can_fault_code, lin_fault_code,
            aux_supply_ok, transceiver_supply_ok, c,
            transceiver_supply_ok ? can_mode : 2'h0};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic w();
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] f, input logic [15:0] e);
    i_host.xfer(f, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk(d, e);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    w();
  endtask
  task automatic t_status();
    w();
    rd(16'h1000, sw(4'h0, 1'b1));
    enable_pin_high = 1'b0;
    w();
    rd(16'h1000, sw(4'h0, 1'b1));
    $display("status done");
  endtask
  task automatic t_events();
    reset_cause = 4'hB;
    pulse(reset_event);
    repeat (2) rd(16'h1000, sw(4'hB, 1'b1));
    pulse(normal_entered);
    rd(16'h1000, sw(4'hB, 1'b0));
    pulse(power_on_reset);
    rd(16'h1000, sw(4'hB, 1'b1));
    $display("events done");
  endtask
  task automatic t_diag();
    can_fault_irq_enable = 1'b1;
    for (int i = 0; i < 16; i++) begin
      can_fault_code   = i[3:0];
      lin_fault_code   = i[1:0];
      can_mode         = i[3:2];
      ground_shift_out = i[0];
      @(negedge clk_sys);
      chk({15'h0, can_fault_irq}, {15'h0, i != 0});
      @(negedge clk_sys);
      rd(16'h3000, dw(4'h3, 1'b1));
    end
    $display("diag done");
  endtask
  task automatic t_write();
    rd(16'h2ABC, dw(4'h2, 1'b1));
    chk({15'h0, mode_write}, 16'h0001);
    chk({4'h0, mode_reg}, 16'h0ABC);
    rd(16'h3555, dw(4'h3, 1'b1));
    chk({15'h0, mode_write}, 16'h0000);
    chk({4'h0, mode_reg}, 16'h0ABC);
    i_host.xfer(16'h7000, d, ok);
    chk({15'h0, ok}, 16'h0000);
    $display("write done");
  endtask
  task automatic t_supply();
    supply_fault_irq_enable = 1'b1;
    transceiver_supply_ok = 1'b0;
    w();
    chk({15'h0, supply_irq}, 16'h0001);
    rd(16'h3000, dw(4'h3, 1'b1));
    transceiver_supply_ok = 1'b1;
    w();
    rd(16'h3000, dw(4'h3, 1'b1));
    aux_supply_ok = 1'b0;
    w();
    rd(16'h3000, dw(4'h3, 1'b1));
    aux_supply_ok = 1'b1;
    pulse(core_supply_uv);
    rd(16'h3000, dw(4'h3, 1'b0));
    rd(16'h3000, dw(4'h3, 1'b1));
    $display("supply done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {srst, reset_event, power_on_reset, normal_entered} = 4'h8;
    {enable_pin_high, aux_supply_ok, transceiver_supply_ok} = 3'h7;
    {ground_shift_out, core_supply_uv} = 2'h0;
    {supply_fault_irq_enable, can_fault_irq_enable} = 2'h0;
    {reset_cause, can_fault_code, lin_fault_code, can_mode} = 12'h000;
    status_misc = 7'h55;
    n_mismatch = 0;
    n_checks = 0;
    repeat (12) @(negedge clk_sys);
    srst = 1'b0;
    t_status();
    t_events();
    t_diag();
    t_write();
    t_supply();
    tally_and_finish();
  end
endmodule
`default_nettype wire
